// file: inc/ssbs_regs.svh
// Register map, field positions, reset values and timing constants of the stop sequencer
`ifndef SSBS_REGS_SVH
`define SSBS_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SSBS_ADR_CTRL   8'h00
`define SSBS_ADR_VTH    8'h04
`define SSBS_ADR_TMO    8'h08
`define SSBS_ADR_DBI    8'h0C
`define SSBS_ADR_UVF    8'h10
`define SSBS_ADR_OVT    8'h14
`define SSBS_ADR_CHOP   8'h18
`define SSBS_ADR_STAT   8'h1C
`define SSBS_ADR_FAULT  8'h20

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define SSBS_CTRL_SWEN   0
`define SSBS_CTRL_BRKFN  1
`define SSBS_CTRL_MODE   3:2
`define SSBS_CTRL_IMM    4
`define SSBS_CTRL_STOPIN 5
`define SSBS_CTRL_W      6
`define SSBS_CTRL_RST    6'h02

// Disable mode: bit 1 selects deceleration, bit 0 dynamic braking
`define SSBS_MODE_DEC    1
`define SSBS_MODE_DB     0

// ----------------------------------------------------------------
// Fault flags and status fields
// ----------------------------------------------------------------
`define SSBS_FLT_OV      0
`define SSBS_FLT_UV      1
`define SSBS_FLT_EXT     2
`define SSBS_FLT_W       3
`define SSBS_STAT_STATE  2:0
`define SSBS_STAT_PWR    3
`define SSBS_STAT_BRK    4
`define SSBS_STAT_DB     5
`define SSBS_STAT_CHOP   6
`define SSBS_STAT_REARM  7

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define SSBS_VTH_RST     16'h0010
`define SSBS_TMO_RST     24'h0F4240
`define SSBS_DBI_RST     16'h0100
`define SSBS_UVF_RST     16'h0100
`define SSBS_OVT_RST     16'hF000
`define SSBS_CHOP_RST    16'hE000
`define SSBS_CLK_KHZ     125000
`define SSBS_BLINK_MS    250
`define SSBS_BLINK_CYC   (`SSBS_BLINK_MS * `SSBS_CLK_KHZ)

`endif

// file: inc/ssbs_pkg.sv
// Types shared by the stop sequencer modules
package ssbs_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    SSBS_DISABLED,
    SSBS_ACTIVE,
    SSBS_DECEL,
    SSBS_COAST,
    SSBS_DYNBRK
  } ssbs_state_t;

  // LED display classes
  typedef enum logic [1:0] {
    SSBS_LED_SAFE,
    SSBS_LED_RUN,
    SSBS_LED_WARN,
    SSBS_LED_FAULT
  } ssbs_led_t;

endpackage : ssbs_pkg

// file: rtl/ssbs_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module ssbs_sync #(
  parameter int unsigned W = 2
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_r;

  // ----------------------------------------------------------------
  // Per-bit flip-flop pair
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          meta_r[i] <= 1'b0;
          dout[i]   <= 1'b0;
        end
        else
        begin
          meta_r[i] <= din[i];
          dout[i]   <= meta_r[i];
        end
      end
    end
  endgenerate

endmodule : ssbs_sync

// file: rtl/ssbs_led.sv
// Status LED colour and blink generator
`timescale 1ns/100ps
`include "ssbs_regs.svh"
module ssbs_led #(
  parameter int unsigned BLINK_CYC = `SSBS_BLINK_CYC
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire ssbs_pkg::ssbs_led_t mode,
  output logic                   led_red,
  output logic                   led_green
);

  logic [31:0] div_r, div_nxt;
  logic [1:0]  ph_r, ph_nxt;
  logic        red_nxt, grn_nxt;
  logic        tick;
  // Blink divider and three-phase sequence
  always_comb
  begin
    tick    = (div_r == BLINK_CYC - 1);
    div_nxt = tick ? 32'h0 : div_r + 32'h1;
    ph_nxt  = ph_r;
    if (tick)
      ph_nxt = (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
    // Orange is red and green together
    case (mode)
      ssbs_pkg::SSBS_LED_RUN:   begin red_nxt = 1'b0;  grn_nxt = 1'b1;  end
      ssbs_pkg::SSBS_LED_WARN:  begin red_nxt = ph_r[0]; grn_nxt = 1'b1; end
      ssbs_pkg::SSBS_LED_SAFE:  begin red_nxt = ph_r[0]; grn_nxt = ph_r[0]; end
      ssbs_pkg::SSBS_LED_FAULT:
      begin
        red_nxt = (ph_r != 2'h2);
        grn_nxt = (ph_r != 2'h0);
      end
      default:                  begin red_nxt = 1'b1;  grn_nxt = 1'b0;  end
    endcase
  end

  // Registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_r     <= 32'h0;
      ph_r      <= 2'h0;
      led_red   <= 1'b0;
      led_green <= 1'b0;
    end
    else
    begin
      div_r     <= div_nxt;
      ph_r      <= ph_nxt;
      led_red   <= red_nxt;
      led_green <= grn_nxt;
    end
  end

endmodule : ssbs_led

// file: rtl/ssbs_core.sv
// Stop and holding-brake sequencer with Wishbone register slave
// Functional notes
// R01 - Hardware enable loss switches power stage off at once, no deceleration.
// R02 - Mode 0: software disable removes drive now; brake on low speed or timeout.
// R03 - Mode 2: software disable decelerates first, then disables; brake as usual.
// R04 - In any stop, brake engages on speed below threshold or timeout.
// R05 - Immediate-brake set: brake engages at once after fault or hardware disable from active or decel, from dynbrk on over-voltage or hw disable only.
// R06 - With brake function on, losing drive-active always leads to brake applied.
// R07 - Stop input decelerates, then disables drive and applies brake.
// R08 - Software sets mode 2 when controlled-deceleration stop categories are needed.
// R09 - Software disable is the software enable going low, handled by mode.
// R10 - Bus over-voltage raises its fault, drops power stage, load coasts.
// R11 - Bus over-voltage opens the fault relay contact.
// R12 - High bus voltage switches the brake chopper on.
// R13 - Dynamic braking shorts terminals on q axis, d-axis current held at zero.
// R14 - Dynamic braking current is clamped to the configured limit.
// R15 - Disable mode selects whether and how dynamic braking is used.
// R16 - LED: green running, green/orange warning, orange safe, red/orange/green fault.
// R17 - Fault reaction depends on fault type, mode and threshold settings.
// R18 - Stop timeout counter starts at stop, clears on brake or re-enable.
// R19 - After stopping, stay disabled until new enable with no fault.
`timescale 1ns/100ps
`include "ssbs_regs.svh"
module ssbs_core #(
  parameter int unsigned BLINK_CYC = `SSBS_BLINK_CYC
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        hw_enable_pin,
  input  wire logic        stop_din_pin,
  input  wire logic        ext_fault,
  input  wire logic        drive_warning,
  input  wire logic [15:0] velocity_abs,
  input  wire logic [15:0] bus_voltage,
  input  wire logic [15:0] motor_current_abs,
  output logic             pwr_stage_en,
  output logic             decel_cmd,
  output logic             brake_apply,
  output logic             drive_active,
  output logic             dynbrake_en,
  output logic             dynbrake_short,
  output logic             d_axis_zero,
  output logic      [15:0] dynbrake_ilim,
  output logic             chopper_on,
  output logic             fault_relay_closed,
  output logic             led_red,
  output logic             led_green
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [`SSBS_CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [15:0]             vth_r, vth_nxt;
  logic [23:0]             tmo_cfg_r, tmo_cfg_nxt;
  logic [15:0]             dbi_r, dbi_nxt;
  logic [15:0]             uvf_r, uvf_nxt;
  logic [15:0]             ovt_r, ovt_nxt;
  logic [15:0]             chop_r, chop_nxt;
  logic [`SSBS_FLT_W-1:0]  fault_r, fault_nxt, fault_set, fault_clr;
  logic [31:0]             rdat_nxt;
  logic                    ack_nxt;
  logic                    wr_en;
  logic [1:0]              pins_s;
  logic                    hw_en_s, stop_s;

  ssbs_pkg::ssbs_state_t   state_r, state_nxt, stop_tgt;
  logic [23:0]             tmo_r, tmo_nxt;
  logic                    brk_r, brk_nxt;
  logic                    rearm_r, rearm_nxt;
  logic                    stopping, stop_done, vel_low, en_req, any_fault, imm;
  logic [1:0]              mode;
  ssbs_pkg::ssbs_led_t     led_mode;

  // Byte-lane merge for writes
  function automatic logic [31:0] ssbs_merge(input logic [31:0] old,
                                             input logic [31:0] wdat,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        r[8*b +: 8] = wdat[8*b +: 8];
    return r;
  endfunction : ssbs_merge

  // Pin inputs into the clock domain
  ssbs_sync #(
    .W (2)
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .din    ({stop_din_pin, hw_enable_pin}),
    .dout   (pins_s)
  );

  assign hw_en_s = pins_s[0];
  assign stop_s  = pins_s[1];

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  // Next register values, read data and acknowledge
  always_comb
  begin
    wr_en       = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
    ack_nxt     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    ctrl_nxt    = ctrl_r;
    vth_nxt     = vth_r;
    tmo_cfg_nxt = tmo_cfg_r;
    dbi_nxt     = dbi_r;
    uvf_nxt     = uvf_r;
    ovt_nxt     = ovt_r;
    chop_nxt    = chop_r;
    fault_clr   = '0;
    rdat_nxt    = 32'h0;
    if (wr_en)
    begin
      case (wb_adr_i)
        `SSBS_ADR_CTRL:
          ctrl_nxt = `SSBS_CTRL_W'(ssbs_merge({26'h0, ctrl_r}, wb_dat_i, wb_sel_i)); // [R09] [R15]
        `SSBS_ADR_VTH:   vth_nxt = 16'(ssbs_merge({16'h0, vth_r}, wb_dat_i, wb_sel_i));
        `SSBS_ADR_TMO:   tmo_cfg_nxt = 24'(ssbs_merge({8'h0, tmo_cfg_r}, wb_dat_i, wb_sel_i));
        `SSBS_ADR_DBI:   dbi_nxt = 16'(ssbs_merge({16'h0, dbi_r}, wb_dat_i, wb_sel_i));
        `SSBS_ADR_UVF:   uvf_nxt = 16'(ssbs_merge({16'h0, uvf_r}, wb_dat_i, wb_sel_i));
        `SSBS_ADR_OVT:   ovt_nxt = 16'(ssbs_merge({16'h0, ovt_r}, wb_dat_i, wb_sel_i));
        `SSBS_ADR_CHOP:  chop_nxt = 16'(ssbs_merge({16'h0, chop_r}, wb_dat_i, wb_sel_i));
        `SSBS_ADR_FAULT: fault_clr = wb_sel_i[0] ? wb_dat_i[`SSBS_FLT_W-1:0] : '0;
        default:         ;
      endcase
    end
    if (ack_nxt && !wb_we_i)
    begin
      case (wb_adr_i)
        `SSBS_ADR_CTRL:  rdat_nxt = {26'h0, ctrl_r};
        `SSBS_ADR_VTH:   rdat_nxt = {16'h0, vth_r};
        `SSBS_ADR_TMO:   rdat_nxt = {8'h0, tmo_cfg_r};
        `SSBS_ADR_DBI:   rdat_nxt = {16'h0, dbi_r};
        `SSBS_ADR_UVF:   rdat_nxt = {16'h0, uvf_r};
        `SSBS_ADR_OVT:   rdat_nxt = {16'h0, ovt_r};
        `SSBS_ADR_CHOP:  rdat_nxt = {16'h0, chop_r};
        `SSBS_ADR_STAT:
        begin
          rdat_nxt[`SSBS_STAT_STATE] = state_r;
          rdat_nxt[`SSBS_STAT_PWR]   = pwr_stage_en;
          rdat_nxt[`SSBS_STAT_BRK]   = brake_apply;
          rdat_nxt[`SSBS_STAT_DB]    = dynbrake_en;
          rdat_nxt[`SSBS_STAT_CHOP]  = chopper_on;
          rdat_nxt[`SSBS_STAT_REARM] = rearm_r;
        end
        `SSBS_ADR_FAULT: rdat_nxt = {29'h0, fault_r};
        default:         rdat_nxt = 32'h0;
      endcase
    end
  end

  // Register slave flops
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_r    <= `SSBS_CTRL_RST;
      vth_r     <= `SSBS_VTH_RST;
      tmo_cfg_r <= `SSBS_TMO_RST;
      dbi_r     <= `SSBS_DBI_RST;
      uvf_r     <= `SSBS_UVF_RST;
      ovt_r     <= `SSBS_OVT_RST;
      chop_r    <= `SSBS_CHOP_RST;
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h0;
    end
    else
    begin
      ctrl_r    <= ctrl_nxt;
      vth_r     <= vth_nxt;
      tmo_cfg_r <= tmo_cfg_nxt;
      dbi_r     <= dbi_nxt;
      uvf_r     <= uvf_nxt;
      ovt_r     <= ovt_nxt;
      chop_r    <= chop_nxt;
      wb_ack_o  <= ack_nxt;
      wb_dat_o  <= rdat_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Fault detection
  // ----------------------------------------------------------------
  // Sticky faults, a new event wins over a clear
  always_comb
  begin
    fault_set                = '0;
    fault_set[`SSBS_FLT_OV]  = (bus_voltage > ovt_r);                   // [R10]
    fault_set[`SSBS_FLT_UV]  = drive_active & (bus_voltage < uvf_r);    // [R17]
    fault_set[`SSBS_FLT_EXT] = ext_fault;
    fault_nxt                = (fault_r & ~fault_clr) | fault_set;
  end

  // Fault flops
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      fault_r <= '0;
    else
      fault_r <= fault_nxt;
  end

  // ----------------------------------------------------------------
  // Stop sequencer
  // ----------------------------------------------------------------
  // State, stop timer, brake and re-arm
  always_comb
  begin
    mode      = ctrl_r[`SSBS_CTRL_MODE];
    any_fault = |fault_set;
    imm       = ctrl_r[`SSBS_CTRL_IMM];
    vel_low   = (velocity_abs < vth_r);
    stopping  = (state_r == ssbs_pkg::SSBS_DECEL) || (state_r == ssbs_pkg::SSBS_COAST) ||
                (state_r == ssbs_pkg::SSBS_DYNBRK);
    stop_done = stopping & (vel_low | (tmo_r == 24'h0));                // [R04]
    en_req    = ctrl_r[`SSBS_CTRL_SWEN] & hw_en_s & ~(|fault_r) & ~rearm_r; // [R19]
    // Fault reaction target: bit 0 dynamic braking, else bit 1 decel
    if (mode[`SSBS_MODE_DB])
      stop_tgt = ssbs_pkg::SSBS_DYNBRK;                                 // [R15] [R17]
    else if (mode[`SSBS_MODE_DEC])
      stop_tgt = ssbs_pkg::SSBS_DECEL;
    else
      stop_tgt = ssbs_pkg::SSBS_COAST;
    state_nxt = state_r;
    tmo_nxt   = tmo_r;
    brk_nxt   = brk_r;
    rearm_nxt = rearm_r & ctrl_r[`SSBS_CTRL_SWEN];                      // [R19]
    case (state_r)
      ssbs_pkg::SSBS_DISABLED:
      begin
        tmo_nxt = 24'h0;
        if (en_req)
        begin
          state_nxt = ssbs_pkg::SSBS_ACTIVE;
          brk_nxt   = 1'b0;
        end
      end
      ssbs_pkg::SSBS_ACTIVE:
      begin
        tmo_nxt = tmo_cfg_r;                                            // [R18]
        if (fault_set[`SSBS_FLT_OV] || !hw_en_s)
        begin
          state_nxt = ssbs_pkg::SSBS_COAST;                             // [R01] [R10]
          brk_nxt   = imm;                                              // [R05]
        end
        else if (any_fault)
        begin
          state_nxt = stop_tgt;                                         // [R17]
          brk_nxt   = imm;                                              // [R05]
        end
        else if (ctrl_r[`SSBS_CTRL_STOPIN] && stop_s)
          state_nxt = ssbs_pkg::SSBS_DECEL;                             // [R07]
        else if (!ctrl_r[`SSBS_CTRL_SWEN])
        begin
          // Software disable: mode 2 decelerates, mode 1 brakes, 0 coasts
          if (mode[`SSBS_MODE_DEC])
            state_nxt = ssbs_pkg::SSBS_DECEL;                           // [R03] [R09]
          else if (mode[`SSBS_MODE_DB])
            state_nxt = ssbs_pkg::SSBS_DYNBRK;                          // [R15]
          else
            state_nxt = ssbs_pkg::SSBS_COAST;                           // [R02] [R09]
        end
        if (state_nxt != ssbs_pkg::SSBS_ACTIVE)
          rearm_nxt = 1'b1;
      end
      ssbs_pkg::SSBS_DECEL, ssbs_pkg::SSBS_COAST, ssbs_pkg::SSBS_DYNBRK:
      begin
        tmo_nxt = (tmo_r == 24'h0) ? 24'h0 : tmo_r - 24'h1;             // [R18]
        if (stop_done)
        begin
          state_nxt = ssbs_pkg::SSBS_DISABLED;                          // [R04] [R19]
          brk_nxt   = 1'b1;                                             // [R06]
          tmo_nxt   = 24'h0;                                            // [R18]
        end
        else if (state_r != ssbs_pkg::SSBS_COAST &&
                 (fault_set[`SSBS_FLT_OV] || !hw_en_s))
        begin
          state_nxt = ssbs_pkg::SSBS_COAST;                             // [R01] [R10]
          brk_nxt   = brk_r | imm;                                      // [R05]
        end
        else if (state_r == ssbs_pkg::SSBS_DECEL && any_fault)
          brk_nxt = brk_r | imm;                                        // [R05]
      end
      default:
      begin
        state_nxt = ssbs_pkg::SSBS_DISABLED;
        brk_nxt   = 1'b1;
      end
    endcase
  end

  // Sequencer flops
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= ssbs_pkg::SSBS_DISABLED;
      tmo_r   <= 24'h0;
      brk_r   <= 1'b1;
      rearm_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      tmo_r   <= tmo_nxt;
      brk_r   <= brk_nxt;
      rearm_r <= rearm_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Power stage, brake and supply outputs
  // ----------------------------------------------------------------
  // Output flops follow the next state; chopper_on and dynbrake_ilim follow their inputs
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pwr_stage_en       <= 1'b0;
      decel_cmd          <= 1'b0;
      drive_active       <= 1'b0;
      brake_apply        <= 1'b0;
      dynbrake_en        <= 1'b0;
      dynbrake_short     <= 1'b0;
      d_axis_zero        <= 1'b0;
      dynbrake_ilim      <= 16'h0;
      chopper_on         <= 1'b0;
      fault_relay_closed <= 1'b0;
    end
    else
    begin
      pwr_stage_en   <= (state_nxt == ssbs_pkg::SSBS_ACTIVE) ||
                        (state_nxt == ssbs_pkg::SSBS_DECEL);          // [R01] [R02]
      decel_cmd      <= (state_nxt == ssbs_pkg::SSBS_DECEL);          // [R03] [R07]
      drive_active   <= (state_nxt == ssbs_pkg::SSBS_ACTIVE);
      brake_apply    <= brk_nxt & ctrl_r[`SSBS_CTRL_BRKFN];           // [R06]
      dynbrake_en    <= (state_nxt == ssbs_pkg::SSBS_DYNBRK);         // [R13]
      dynbrake_short <= (state_nxt == ssbs_pkg::SSBS_DYNBRK) &&
                        (motor_current_abs < dbi_r);                  // [R14]
      d_axis_zero    <= (state_nxt == ssbs_pkg::SSBS_DYNBRK);         // [R13]
      dynbrake_ilim  <= dbi_r;                                        // [R14]
      chopper_on     <= (bus_voltage > chop_r);                       // [R12]
      fault_relay_closed <= ~fault_nxt[`SSBS_FLT_OV];                 // [R11]
    end
  end

  // ----------------------------------------------------------------
  // Status LED
  // ----------------------------------------------------------------
  // Display class from fault, running and warning
  always_comb
  begin
    if (|fault_r)
      led_mode = ssbs_pkg::SSBS_LED_FAULT;                            // [R16]
    else if (drive_active && drive_warning)
      led_mode = ssbs_pkg::SSBS_LED_WARN;
    else if (drive_active)
      led_mode = ssbs_pkg::SSBS_LED_RUN;
    else
      led_mode = ssbs_pkg::SSBS_LED_SAFE;
  end

  ssbs_led #(
    .BLINK_CYC (BLINK_CYC)
  ) u_led (
    .clk       (clk),
    .arst_n    (arst_n),
    .mode      (led_mode),
    .led_red   (led_red),
    .led_green (led_green)
  );

endmodule : ssbs_core

// file: dv/ssbs_chk.sv
// Port-level checker for the stop and brake sequencer
`timescale 1ns/100ps
module ssbs_chk (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        hw_enable_pin,
  input wire logic [15:0] motor_current_abs,
  input wire logic        pwr_stage_en,
  input wire logic        decel_cmd,
  input wire logic        brake_apply,
  input wire logic        drive_active,
  input wire logic        dynbrake_en,
  input wire logic        dynbrake_short,
  input wire logic        d_axis_zero,
  input wire logic [15:0] dynbrake_ilim
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  hw_coast_a: assert property (!hw_enable_pin [*3] |=>
    !pwr_stage_en && !decel_cmd && !dynbrake_en) else $error("stage on after hw disable");
  decel_pwr_a: assert property (decel_cmd |-> pwr_stage_en && !drive_active)
    else $error("decel without power stage");
  act_brake_a: assert property (drive_active |-> pwr_stage_en && !brake_apply)
    else $error("active drive with brake");
  pwr_brake_a: assert property (pwr_stage_en && !decel_cmd |-> !brake_apply)
    else $error("brake while stage on");
  db_dzero_a: assert property (dynbrake_en |-> d_axis_zero && !pwr_stage_en)
    else $error("dynbrake without d-axis zero");
  db_clamp_a: assert property (motor_current_abs >= dynbrake_ilim |=> !dynbrake_short)
    else $error("short kept above current limit");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_late_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
  cover property ($rose(dynbrake_en));
  cover property ($rose(decel_cmd));
  cover property ($rose(brake_apply));
endmodule : ssbs_chk

bind ssbs_core ssbs_chk chk_u (.clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
  .hw_enable_pin, .motor_current_abs, .pwr_stage_en, .decel_cmd, .brake_apply,
  .drive_active, .dynbrake_en, .dynbrake_short, .d_axis_zero, .dynbrake_ilim);

// file: dv/ssbs_plant.sv
// Behavioural motor, power stage and shorted-terminal current model
`timescale 1ns/100ps
module ssbs_plant (
  input  wire logic        clk,
  input  wire logic        load,
  input  wire logic [15:0] set_vel,
  input  wire logic        pwr_stage_en,
  input  wire logic        decel_cmd,
  input  wire logic        dynbrake_en,
  input  wire logic        dynbrake_short,
  output logic      [15:0] velocity_abs,
  output logic      [15:0] motor_current_abs
);
  logic [15:0] vel_r = 16'h0;
  logic [2:0]  div_r = 3'h0;
  // Speed held by the loop, ramps in decel, bleeds when shorted or coasting
  always_ff @(posedge clk)
  begin
    div_r <= div_r + 3'h1;
    if (load)
      vel_r <= set_vel;
    else if (vel_r != 16'h0 && (decel_cmd || dynbrake_short || (!pwr_stage_en && div_r == 3'h0)))
      vel_r <= vel_r - 16'h1;
  end
  // Back-EMF current only flows in dynamic braking
  assign velocity_abs      = vel_r;
  assign motor_current_abs = dynbrake_en ? vel_r : 16'h0;
endmodule : ssbs_plant

// file: dv/test_servo_stop_brake_sequencer.sv
// Self-checking bench for the stop and brake sequencer
`timescale 1ns/100ps
`include "ssbs_regs.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module test_servo_stop_brake_sequencer;
  logic clk = 1'b0, arst_n = 1'b0, load = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0]  wb_adr_i = 8'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd_val;
  logic [3:0]  wb_sel_i = 4'hF;
  logic hw_enable_pin = 1'b0, stop_din_pin = 1'b0, ext_fault = 1'b0, drive_warning = 1'b0;
  logic [15:0] bus_voltage = 16'h8000, set_vel = 16'h0, velocity_abs, motor_current_abs;
  logic pwr_stage_en, decel_cmd, brake_apply, drive_active, dynbrake_en, dynbrake_short;
  logic d_axis_zero, chopper_on, fault_relay_closed, led_red, led_green;
  logic [15:0] dynbrake_ilim;
  int bad_count = 0, checks = 0;
  // ----------------------------------------
  // Design, far side and clock
  // ----------------------------------------
  ssbs_core #(.BLINK_CYC(4)) dut_u (.clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .hw_enable_pin, .stop_din_pin, .ext_fault,
    .drive_warning, .velocity_abs, .bus_voltage, .motor_current_abs, .pwr_stage_en,
    .decel_cmd, .brake_apply, .drive_active, .dynbrake_en, .dynbrake_short, .d_axis_zero,
    .dynbrake_ilim, .chopper_on, .fault_relay_closed, .led_red, .led_green);
  ssbs_plant plant_u (.clk, .load, .set_vel, .pwr_stage_en, .decel_cmd, .dynbrake_en,
    .dynbrake_short, .velocity_abs, .motor_current_abs);
  always #4 clk = ~clk;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task give_verdict;
    if (bad_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  // One classic Wishbone cycle, held until ack is sampled
  task automatic wb_io(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++)
      @(posedge clk);
    rd_val = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    if (i == 20)
    begin
      bad_count++;
      give_verdict();
    end
  endtask : wb_io
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb_io(1'b0, a, 32'h0);
    `CHK(rd_val, e)
  endtask : rd_chk
  // Bounded wait: 0 brake applied, 1 drive active, 2 power stage off
  task automatic wait_for(input int w);
    int i;
    for (i = 0; i < 3000; i++)
    begin
      @(posedge clk);
      if ((w == 0 && brake_apply === 1'b1) || (w == 1 && drive_active === 1'b1)
          || (w == 2 && pwr_stage_en === 1'b0))
        break;
    end
    if (i == 3000)
    begin
      bad_count++;
      give_verdict();
    end
  endtask : wait_for
  // Load speed, rearm, then enable with control c
  task automatic run(input logic [15:0] v, input logic [31:0] c);
    set_vel <= v;
    load    <= 1'b1;
    @(posedge clk);
    load    <= 1'b0;
    wb_io(1'b1, `SSBS_ADR_CTRL, c & 32'h3E);
    wb_io(1'b1, `SSBS_ADR_CTRL, c);
    wait_for(1);
  endtask : run
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    arst_n        <= 1'b1;
    hw_enable_pin <= 1'b1;
    rd_chk(`SSBS_ADR_CTRL, 32'h2);
    rd_chk(`SSBS_ADR_VTH, 32'h10);
    rd_chk(`SSBS_ADR_TMO, 32'h0F4240);
    rd_chk(8'h24, 32'h0);
    `CHK(brake_apply, 1'b1)
    run(16'd40, 32'h03);
    drive_warning <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK(led_green, 1'b1)
    drive_warning <= 1'b0;
    wb_io(1'b1, `SSBS_ADR_CTRL, 32'h02);
    repeat (2) @(posedge clk);
    `CHK(pwr_stage_en, 1'b0)
    `CHK(brake_apply, 1'b0)
    wait_for(0);
    `CHK(velocity_abs < 16'h0010, 1'b1)
    repeat (20) @(posedge clk);
    `CHK(drive_active, 1'b0)
    run(16'd40, 32'h0B);
    wb_io(1'b1, `SSBS_ADR_CTRL, 32'h0A);
    repeat (2) @(posedge clk);
    `CHK({decel_cmd, pwr_stage_en}, 2'b11)
    wait_for(2);
    wait_for(0);
    `CHK(decel_cmd, 1'b0)
    wb_io(1'b1, `SSBS_ADR_DBI, 32'h20);
    run(16'd40, 32'h07);
    wb_io(1'b1, `SSBS_ADR_CTRL, 32'h06);
    repeat (4) @(posedge clk);
    `CHK({dynbrake_en, d_axis_zero}, 2'b11)
    `CHK({dynbrake_short, dynbrake_ilim}, 17'h00020)
    wait_for(0);
    run(16'd40, 32'h23);
    stop_din_pin <= 1'b1;
    repeat (5) @(posedge clk);
    `CHK(decel_cmd, 1'b1)
    wait_for(0);
    stop_din_pin <= 1'b0;
    wb_io(1'b1, `SSBS_ADR_TMO, 32'd20);
    run(16'd40, 32'h1B);
    hw_enable_pin <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK({pwr_stage_en, decel_cmd, brake_apply}, 3'b001)
    hw_enable_pin <= 1'b1;
    run(16'd1000, 32'h03);
    wb_io(1'b1, `SSBS_ADR_CTRL, 32'h02);
    repeat (10) @(posedge clk);
    `CHK(brake_apply, 1'b0)
    repeat (20) @(posedge clk);
    `CHK(brake_apply, 1'b1)
    run(16'd40, 32'h03);
    bus_voltage <= 16'hF100;
    repeat (3) @(posedge clk);
    `CHK({chopper_on, fault_relay_closed, pwr_stage_en, decel_cmd}, 4'b1000)
    rd_chk(`SSBS_ADR_FAULT, 32'h1);
    bus_voltage <= 16'h8000;
    ext_fault   <= 1'b1;
    wb_io(1'b1, `SSBS_ADR_FAULT, 32'h1);
    `CHK({chopper_on, fault_relay_closed}, 2'b01)
    ext_fault <= 1'b0;
    wb_io(1'b1, `SSBS_ADR_CTRL, 32'h03);
    repeat (5) @(posedge clk);
    `CHK(drive_active, 1'b0)
    wb_io(1'b1, `SSBS_ADR_FAULT, 32'h4);
    rd_chk(`SSBS_ADR_FAULT, 32'h0);
    give_verdict();
  end
endmodule : test_servo_stop_brake_sequencer
